// >>> hw/hpiop_top.sv
/*
 handshake parallel I/O port: three 8-bit ports, mode 0/1/2 handshakes on
 port C, register port, sticky event status with mask and one interrupt line.
 assumes pin inputs synchronous to MCLK; pins as input, output and enable.
*/
//----------------------------------------
//----------------------------------------
`timescale 1ns/10ps
`default_nettype none
module hpiop_top (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // register port
    input wire logic [hpiop_pkg::AW-1:0] ADDR,
    input wire logic [hpiop_pkg::DW-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [hpiop_pkg::DW-1:0] RDATA,
    output logic IRQ,
    // port a pins
    input wire logic [7:0] PA_IN,
    output logic [7:0] PA_OUT,
    output logic [7:0] PA_OE,
    // port b pins
    input wire logic [7:0] PB_IN,
    output logic [7:0] PB_OUT,
    output logic [7:0] PB_OE,
    // port c pins
    input wire logic [7:0] PC_IN,
    output logic [7:0] PC_OUT,
    output logic [7:0] PC_OE
);
    import hpiop_pkg::*;
    logic rst_n;
    logic [7:0] pa_lat_r, pa_lat_nxt, pb_lat_r, pb_lat_nxt, pc_lat_r, pc_lat_nxt;
    logic [7:0] ctrl_raw_r, ctrl_raw_nxt, ien_raw_r, ien_raw_nxt, rdata_r, rdata_nxt;
    logic [NEV-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
    hpiop_ctrl_t ctrl;
    hpiop_ien_t ien;
    logic a_hs_in, a_hs_out, b_hs_in, b_hs_out;
    logic host_rd_a, host_wr_a, host_rd_b, host_wr_b;
    logic [7:0] a_latch, b_latch, a_rd, b_rd, pc_rd;
    logic [7:0] hs_use, hs_oe, hs_val, gen_out;
    hpiop_hs_t hs_a, hs_b;

    hpiop_rst_sync u_rst (
        .clk(MCLK),
        .arst_n(RESETN),
        .rst_n(rst_n)
    );

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    assign ctrl = hpiop_ctrl_t'(ctrl_raw_r);
    assign ien = hpiop_ien_t'(ien_raw_r);
    // code 3 of mode A is not a mode: it falls back to plain I/O
    assign a_hs_in = (ctrl.mode_a == MODE_STROBED && ctrl.a_in) || ctrl.mode_a == MODE_BIDIR;
    assign a_hs_out = (ctrl.mode_a == MODE_STROBED && !ctrl.a_in) || ctrl.mode_a == MODE_BIDIR;
    // bidirectional A leaves PC2..PC0 general, so group B cannot handshake then
    assign b_hs_in = ctrl.mode_b && ctrl.b_in && ctrl.mode_a != MODE_BIDIR;
    assign b_hs_out = ctrl.mode_b && !ctrl.b_in && ctrl.mode_a != MODE_BIDIR;

    // internal one-cycle strobes toward the channels
    assign host_rd_a = RD_STB && ADDR == OFS_PORT_A;
    assign host_wr_a = WR_STB && ADDR == OFS_PORT_A;
    assign host_rd_b = RD_STB && ADDR == OFS_PORT_B;
    assign host_wr_b = WR_STB && ADDR == OFS_PORT_B;

    // ----------------------------------------
    // handshake channels
    // ----------------------------------------
    hpiop_hs u_hs_a (
        .clk(MCLK),
        .rst_n(rst_n),
        .in_en(a_hs_in),
        .out_en(a_hs_out),
        .ie_in(ien.ie_a_in),
        .ie_out(ien.ie_a_out),
        .stb_n(PC_IN[4]),
        .ack_n(PC_IN[6]),
        .din(PA_IN),
        .host_rd(host_rd_a),
        .host_wr(host_wr_a),
        .in_latch(a_latch),
        .st(hs_a)
    );

    hpiop_hs u_hs_b (
        .clk(MCLK),
        .rst_n(rst_n),
        .in_en(b_hs_in),
        .out_en(b_hs_out),
        .ie_in(ien.ie_b),
        .ie_out(ien.ie_b),
        .stb_n(PC_IN[2]),
        .ack_n(PC_IN[2]),
        .din(PB_IN),
        .host_rd(host_rd_b),
        .host_wr(host_wr_b),
        .in_latch(b_latch),
        .st(hs_b)
    );

    // ----------------------------------------
    // port c line roles
    // ----------------------------------------
    always_comb begin
        hs_use = 8'h00;
        hs_oe = 8'h00;
        hs_val = 8'h00;
        if (a_hs_out) begin
            hs_use[7:6] = 2'h3;
            hs_oe[7] = 1'b1;
            hs_val[7] = hs_a.obf_n;
        end
        if (a_hs_in) begin
            hs_use[5:4] = 2'h3;
            hs_oe[5] = 1'b1;
            hs_val[5] = hs_a.input_latch_full;
        end
        if (a_hs_in || a_hs_out) begin
            hs_use[3] = 1'b1;
            hs_oe[3] = 1'b1;
            hs_val[3] = hs_a.srq;
        end
        if (b_hs_in || b_hs_out) begin
            hs_use[2:0] = 3'h7;
            hs_oe[1:0] = 2'h3;
            hs_val[1] = b_hs_in ? hs_b.input_latch_full : hs_b.obf_n;
            hs_val[0] = hs_b.srq;
        end
    end

    // one loop serves every port C line: handshake role or general half
    for (genvar i = 0; i < 8; i++) begin : g_pc
        if (i >= 4) begin : g_hi
            assign gen_out[i] = !ctrl.c_hi_in;
        end else begin : g_lo
            assign gen_out[i] = !ctrl.c_lo_in;
        end
        assign PC_OE[i] = hs_use[i] ? hs_oe[i] : gen_out[i];
        assign PC_OUT[i] = hs_use[i] ? hs_val[i] : pc_lat_r[i];
        assign pc_rd[i] = hs_use[i] ? (hs_oe[i] ? hs_val[i] : PC_IN[i])
                                    : (gen_out[i] ? pc_lat_r[i] : PC_IN[i]);
    end

    // ----------------------------------------
    // ports a and b drive
    // ----------------------------------------
    assign PA_OUT = pa_lat_r;
    // bidirectional A drives the bus only while the far end acknowledges
    assign PA_OE = (ctrl.mode_a == MODE_BIDIR) ? {8{!PC_IN[6]}} : {8{!ctrl.a_in}};
    assign PB_OUT = pb_lat_r;
    assign PB_OE = {8{!ctrl.b_in}};
    assign a_rd = a_hs_in ? a_latch : (PA_OE[0] ? pa_lat_r : PA_IN);
    assign b_rd = b_hs_in ? b_latch : (PB_OE[0] ? pb_lat_r : PB_IN);

    // ----------------------------------------
    // events and interrupt
    // ----------------------------------------
    assign ev[ST_A_IN] = hs_a.ev_in;
    assign ev[ST_A_ACK] = hs_a.ev_ack;
    assign ev[ST_B_IN] = hs_b.ev_in;
    assign ev[ST_B_ACK] = hs_b.ev_ack;
    assign IRQ = |(stat_r & mask_r);

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always_comb begin
        pa_lat_nxt = pa_lat_r;
        pb_lat_nxt = pb_lat_r;
        pc_lat_nxt = pc_lat_r;
        ctrl_raw_nxt = ctrl_raw_r;
        ien_raw_nxt = ien_raw_r;
        mask_nxt = mask_r;
        rdata_nxt = 8'h00;
        // an event in the clearing read's cycle survives the clear
        stat_nxt = ((RD_STB && ADDR == OFS_STAT) ? 4'h0 : stat_r) | ev;
        if (WR_STB) begin
            unique case (ADDR)
                OFS_PORT_A: pa_lat_nxt = WDATA;
                OFS_PORT_B: pb_lat_nxt = WDATA;
                OFS_PORT_C: pc_lat_nxt = WDATA;
                OFS_CTRL: ctrl_raw_nxt = WDATA;
                OFS_IEN: ien_raw_nxt = WDATA;
                OFS_MASK: mask_nxt = WDATA[NEV-1:0];
                default: ;
            endcase
        end
        if (RD_STB) begin
            unique case (ADDR)
                OFS_PORT_A: rdata_nxt = a_rd;
                OFS_PORT_B: rdata_nxt = b_rd;
                OFS_PORT_C: rdata_nxt = pc_rd;
                OFS_CTRL: rdata_nxt = ctrl_raw_r;
                OFS_IEN: rdata_nxt = ien_raw_r;
                OFS_STAT: rdata_nxt = {4'h0, stat_r};
                OFS_MASK: rdata_nxt = {4'h0, mask_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pa_lat_r <= LAT_RST;
            pb_lat_r <= LAT_RST;
            pc_lat_r <= LAT_RST;
            ctrl_raw_r <= CTRL_RST;
            ien_raw_r <= IEN_RST;
            mask_r <= MASK_RST;
            stat_r <= 4'h0;
            rdata_r <= 8'h00;
        end else begin
            pa_lat_r <= pa_lat_nxt;
            pb_lat_r <= pb_lat_nxt;
            pc_lat_r <= pc_lat_nxt;
            ctrl_raw_r <= ctrl_raw_nxt;
            ien_raw_r <= ien_raw_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign RDATA = rdata_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n);
    basic_halves_a: assert property (!a_hs_in && !a_hs_out && !b_hs_in && !b_hs_out
        |-> PC_OE == {{4{!ctrl.c_hi_in}}, {4{!ctrl.c_lo_in}}})
        else $error("port C halves not following their directions");
    in_roles_a: assert property (ctrl.mode_a == MODE_STROBED && ctrl.a_in
        |-> PC_OE[5] && !PC_OE[4] && PC_OUT[5] == hs_a.input_latch_full && PC_OUT[3] == hs_a.srq)
        else $error("strobed input roles wrong on port C");
    out_roles_a: assert property (ctrl.mode_a == MODE_STROBED && !ctrl.a_in
        |-> PC_OE[7] && !PC_OE[6] && PC_OUT[7] == hs_a.obf_n)
        else $error("strobed output roles wrong on port C");
    bidir_roles_a: assert property (ctrl.mode_a == MODE_BIDIR
        |-> PC_OE[2:0] == {3{!ctrl.c_lo_in}} && PC_OUT[2:0] == pc_lat_r[2:0])
        else $error("low port C lines not general in bidirectional mode");
    mode_drive_a: assert property (ctrl.mode_a == MODE_BIDIR && !PC_IN[6] |-> PA_OE == 8'hff)
        else $error("port A not driven during acknowledge");
    read_clear_a: assert property (a_hs_in && host_rd_a && PC_IN[4] ##1 a_hs_in |-> !hs_a.input_latch_full)
        else $error("reading port A left input full set");
    irq_sticky_a: assert property (ev[ST_A_IN] && mask_r[ST_A_IN] |=> IRQ ##1 $past(RD_STB) || IRQ)
        else $error("interrupt lost after input event");
endmodule // hpiop_top
`default_nettype wire

// >>> hw/hpiop_pkg.sv
/*
 package for the handshake parallel I/O port: register offsets, reset values,
 mode codes and the structs that carry grouped signals.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package hpiop_pkg;
    // ----------------------------------------
    // widths and register offsets
    // ----------------------------------------
    localparam int DW = 8;
    localparam int AW = 3;
    localparam logic [2:0] OFS_PORT_A = 3'h0;
    localparam logic [2:0] OFS_PORT_B = 3'h1;
    localparam logic [2:0] OFS_PORT_C = 3'h2;
    localparam logic [2:0] OFS_CTRL = 3'h3;
    localparam logic [2:0] OFS_IEN = 3'h4;
    localparam logic [2:0] OFS_STAT = 3'h5;
    localparam logic [2:0] OFS_MASK = 3'h6;
    // ----------------------------------------
    // modes and fields
    // ----------------------------------------
    localparam logic [1:0] MODE_BASIC = 2'h0;
    localparam logic [1:0] MODE_STROBED = 2'h1;
    localparam logic [1:0] MODE_BIDIR = 2'h2;
    typedef struct packed {
        logic spare;
        logic c_lo_in;
        logic c_hi_in;
        logic b_in;
        logic a_in;
        logic mode_b;
        logic [1:0] mode_a;
    } hpiop_ctrl_t;
    typedef struct packed {
        logic [4:0] spare;
        logic ie_b;
        logic ie_a_out;
        logic ie_a_in;
    } hpiop_ien_t;
    localparam int NEV = 4;
    localparam int ST_A_IN = 0;
    localparam int ST_A_ACK = 1;
    localparam int ST_B_IN = 2;
    localparam int ST_B_ACK = 3;
    // ----------------------------------------
    // reset values: every line an input, mode 0
    // ----------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h78;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [7:0] LAT_RST = 8'h00;
    // handshake channel status
    typedef struct packed {
        logic input_latch_full;
        logic obf_n;
        logic srq;
        logic ev_in;
        logic ev_ack;
    } hpiop_hs_t;
endpackage
`default_nettype wire

// >>> hw/hpiop_rst_sync.sv
/*
 reset release synchroniser: async assert, release after two clock edges.
 assumes an active low reset and a free running clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hpiop_rst_sync (
    // clock and raw reset
    input wire logic clk,
    input wire logic arst_n,
    // released reset
    output logic rst_n
);
    logic s1_r;
    logic s2_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= 1'b1;
            s2_r <= s1_r;
        end
    end
    assign rst_n = s2_r;
endmodule // hpiop_rst_sync
`default_nettype wire

// >>> hw/hpiop_hs.sv
/*
 one handshake channel: input latch with strobe and full flag, output full
 flag with acknowledge, and service request flags.
 assumes pins already synchronous to clk and one-cycle host strobes.
*/
`timescale 1ns/10ps
`default_nettype none
module hpiop_hs (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic in_en,
    input wire logic out_en,
    input wire logic ie_in,
    input wire logic ie_out,
    // external handshake
    input wire logic stb_n,
    input wire logic ack_n,
    input wire logic [hpiop_pkg::DW-1:0] din,
    // host side
    input wire logic host_rd,
    input wire logic host_wr,
    output logic [hpiop_pkg::DW-1:0] in_latch,
    output hpiop_pkg::hpiop_hs_t st
);
    import hpiop_pkg::*;
    logic [DW-1:0] lat_r, lat_nxt;
    logic ibf_r, ibf_nxt, obf_n_r, obf_n_nxt;
    logic sin_r, sin_nxt, sout_r, sout_nxt;
    logic stb_q_r, ack_q_r;
    logic stb_rise, ack_rise;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        stb_rise = in_en && stb_n && !stb_q_r;
        ack_rise = out_en && ack_n && !ack_q_r;
        lat_nxt = (in_en && !stb_n) ? din : lat_r;
        if (!in_en) begin
            ibf_nxt = 1'b0;
        end else if (!stb_n) begin
            ibf_nxt = 1'b1;
        end else begin
            ibf_nxt = ibf_r && !host_rd;
        end
        // a host write beside an acknowledge wins: the new byte must be announced
        if (!out_en) begin
            obf_n_nxt = 1'b1;
        end else if (host_wr) begin
            obf_n_nxt = 1'b0;
        end else begin
            obf_n_nxt = obf_n_r || !ack_n;
        end
        sin_nxt = in_en && (stb_rise || (sin_r && !host_rd));
        sout_nxt = out_en && (ack_rise || (sout_r && !host_wr));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_r <= LAT_RST;
            ibf_r <= 1'b0;
            obf_n_r <= 1'b1;
            sin_r <= 1'b0;
            sout_r <= 1'b0;
            stb_q_r <= 1'b1;
            ack_q_r <= 1'b1;
        end else begin
            lat_r <= lat_nxt;
            ibf_r <= ibf_nxt;
            obf_n_r <= obf_n_nxt;
            sin_r <= sin_nxt;
            sout_r <= sout_nxt;
            stb_q_r <= stb_n;
            ack_q_r <= ack_n;
        end
    end

    assign in_latch = lat_r;
    assign st.input_latch_full = ibf_r;
    assign st.obf_n = obf_n_r;
    assign st.srq = (sin_r && ie_in) || (sout_r && ie_out);
    assign st.ev_in = stb_rise;
    assign st.ev_ack = out_en && !ack_n && ack_q_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    latch_capture_a: assert property (in_en && !stb_n |=> lat_r == $past(din))
        else $error("input latch missed strobed data");
    full_raise_a: assert property (in_en && !stb_n ##1 in_en |-> st.input_latch_full)
        else $error("input full not raised after strobe");
    full_clear_a: assert property (in_en && stb_n && ibf_r && host_rd |=> !st.input_latch_full)
        else $error("input full not cleared by host read");
    out_full_a: assert property (out_en && host_wr |=> !st.obf_n)
        else $error("output full not driven low after write");
    out_ack_a: assert property (out_en && !ack_n && !host_wr ##1 out_en |-> st.obf_n)
        else $error("output full not released by acknowledge");
    srq_raise_a: assert property (stb_rise && ie_in |=> ie_in |-> st.srq)
        else $error("service request missing after strobe");
    srq_gate_a: assert property (st.srq |-> ie_in || ie_out)
        else $error("service request without enable");
    srq_clear_a: assert property (!out_en && host_rd && !stb_rise |=> !st.srq)
        else $error("service request kept after servicing read");
endmodule // hpiop_hs
`default_nettype wire

// >>> testbench/hpiop_ext.sv
/*
 behavioural far-side device: strobes bytes into the block, acknowledges
 bytes out of it. assumes the bench calls its tasks from one process.
*/
`timescale 1ns/10ps
`default_nettype none
module hpiop_ext (
    // clock
    input wire logic clk,
    // port c as the block drives it
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe,
    // pin levels toward the block
    output logic [7:0] pa_in,
    output logic [7:0] pb_in,
    output logic [7:0] pc_in
);
    //----------------------------------------
    // wire levels
    //----------------------------------------
    logic [7:0] ext = 8'hff;
    // handshake lines idle high; a driven line reads back its own level
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & ext);
    initial begin
        pa_in = 8'h00;
        pb_in = 8'h00;
    end
    //----------------------------------------
    // handshakes
    //----------------------------------------
    task automatic strobe(input int ln, input logic [7:0] d, input logic grp_b);
        @(posedge clk);
        if (grp_b) begin
            pb_in <= d;
        end else begin
            pa_in <= d;
        end
        ext[ln] <= 1'b0;
        repeat (2) @(posedge clk);
        ext[ln] <= 1'b1;
        @(posedge clk);
        // hold time over, so the byte must not linger on the lines
        if (grp_b) begin
            pb_in <= ~d;
        end else begin
            pa_in <= ~d;
        end
    endtask
    task automatic ack(input int ln);
        @(posedge clk);
        ext[ln] <= 1'b0;
        repeat (2) @(posedge clk);
        ext[ln] <= 1'b1;
    endtask
endmodule // hpiop_ext
`default_nettype wire

// >>> testbench/hpiop_top_test.sv
/*
 self-checking bench for the handshake parallel I/O port.
 assumes the far-side model hpiop_ext and a 10 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hpiop_top_test;
    import hpiop_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rdata, pa_in, pb_in, pc_in, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe;
    logic irq;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    //----------------------------------------
    // clock, design and far side
    //----------------------------------------
    initial begin
        forever #50 mclk = ~mclk;
    end
    hpiop_top i_hpiop_top (.MCLK(mclk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .IRQ(irq), .PA_IN(pa_in),
        .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe),
        .PC_IN(pc_in), .PC_OUT(pc_out), .PC_OE(pc_oe));
    hpiop_ext i_hpiop_ext (.clk(mclk), .pc_out(pc_out), .pc_oe(pc_oe), .pa_in(pa_in),
        .pb_in(pb_in), .pc_in(pc_in));
    //----------------------------------------
    // shared tasks
    //----------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    //----------------------------------------
    // scenarios
    //----------------------------------------
    task automatic sc_reset();
        logic [7:0] v;
        chk("oe", pa_oe | pb_oe | pc_oe, 8'h00);
        rd(OFS_CTRL, v); chk("ctrl", v, CTRL_RST);
        rd(OFS_IEN, v); chk("ien", v, IEN_RST);
        wr(3'h7, 8'hff);
        rd(3'h7, v); chk("unmapped", v, 8'h00);
    endtask
    task automatic sc_mode0();
        logic [7:0] v;
        wr(OFS_CTRL, 8'h00);
        wr(OFS_PORT_A, 8'ha5);
        wr(OFS_PORT_B, 8'h3c);
        wr(OFS_PORT_C, 8'h96);
        chk("pa_out", pa_out, 8'ha5);
        chk("pb_out", pb_out, 8'h3c);
        chk("pc_out", pc_out, 8'h96);
        chk("pc_oe", pc_oe, 8'hff);
        wr(OFS_CTRL, 8'h20);
        chk("pc_oe_half", pc_oe, 8'h0f);
        rd(OFS_PORT_C, v); chk("pc_read", v, 8'hf6);
    endtask
    task automatic sc_input();
        logic [7:0] v;
        wr(OFS_CTRL, 8'h1d);
        wr(OFS_IEN, 8'h05);
        wr(OFS_MASK, 8'h05);
        chk("in_oe", pc_oe & 8'h3f, 8'h2b);
        i_hpiop_ext.strobe(4, 8'h5a, 1'b0);
        i_hpiop_ext.strobe(2, 8'hc6, 1'b1);
        #1;
        chk("in_flags", pc_out & 8'h2b, 8'h2b);
        chk("in_irq", {7'h00, irq}, 8'h01);
        rd(OFS_STAT, v); chk("in_stat", v, 8'h05);
        chk("irq_clr", {7'h00, irq}, 8'h00);
        rd(OFS_PORT_A, v); chk("latch_a", v, 8'h5a);
        rd(OFS_PORT_B, v); chk("latch_b", v, 8'hc6);
        @(posedge mclk);
        #1;
        chk("in_clear", pc_out & 8'h2b, 8'h00);
    endtask
    task automatic sc_noreq();
        logic [7:0] v;
        wr(OFS_CTRL, 8'h09);
        wr(OFS_IEN, 8'h00);
        wr(OFS_MASK, 8'h01);
        i_hpiop_ext.strobe(4, 8'h11, 1'b0);
        #1;
        chk("no_req", pc_out & 8'h28, 8'h20);
        rd(OFS_STAT, v); chk("nr_stat", v, 8'h01);
        rd(OFS_PORT_A, v); chk("nr_latch", v, 8'h11);
    endtask
    task automatic sc_output();
        logic [7:0] v;
        wr(OFS_CTRL, 8'h01);
        wr(OFS_IEN, 8'h02);
        wr(OFS_MASK, 8'h02);
        chk("out_oe", pc_oe & 8'hc8, 8'h88);
        wr(OFS_PORT_A, 8'hc3);
        chk("out_data", pa_out, 8'hc3);
        chk("out_full", pc_out & 8'h88, 8'h00);
        i_hpiop_ext.ack(6);
        repeat (2) @(posedge mclk);
        #1;
        chk("out_ack", pc_out & 8'h88, 8'h88);
        chk("out_irq", {7'h00, irq}, 8'h01);
        wr(OFS_PORT_A, 8'h3c);
        chk("out_rewr", pc_out & 8'h88, 8'h00);
        rd(OFS_STAT, v); chk("out_stat", v, 8'h02);
    endtask
    // group B output handshake: PC2 acknowledge, PC1 output full, PC0 request
    task automatic sc_out_b();
        logic [7:0] v;
        wr(OFS_CTRL, 8'h04);
        wr(OFS_IEN, 8'h04);
        wr(OFS_MASK, 8'h08);
        chk("b_oe", pc_oe & 8'h07, 8'h03);
        chk("b_pb_oe", pb_oe, 8'hff);
        wr(OFS_PORT_B, 8'h77);
        chk("b_full", pc_out & 8'h03, 8'h00);
        i_hpiop_ext.ack(2);
        repeat (2) @(posedge mclk);
        #1;
        chk("b_ack", pc_out & 8'h03, 8'h03);
        chk("b_irq", {7'h00, irq}, 8'h01);
        rd(OFS_STAT, v); chk("b_stat", v, 8'h08);
        wr(OFS_PORT_B, 8'h78);
        chk("b_rewr", pc_out & 8'h03, 8'h00);
    endtask
    task automatic sc_mode2();
        wr(OFS_CTRL, 8'h02);
        wr(OFS_PORT_C, 8'h05);
        chk("m2_oe", pc_oe, 8'ha8 | 8'h07);
        chk("m2_low", pc_out & 8'h07, 8'h05);
        chk("m2_pa_oe", pa_oe, 8'h00);
    endtask
    //----------------------------------------
    // main sequence
    //----------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        sc_reset();
        sc_mode0();
        sc_input();
        sc_noreq();
        sc_output();
        sc_mode2();
        sc_out_b();
        wrap_up();
    end
endmodule // hpiop_top_test
`default_nettype wire
